// [leq_regs.vh]
`ifndef LEQ_REGS_VH
`define LEQ_REGS_VH

// APB geometry
`define LEQ_ADDR_W        8
`define LEQ_DATA_W        32
`define LEQ_BYTE_LSB_ZERO 2'h0

// Register indices; byte address is four times the index
`define LEQ_IDX_L2_LVL01  6'h09
`define LEQ_IDX_L2_LVL23  6'h0A
`define LEQ_IDX_L3_LVL01  6'h0B
`define LEQ_IDX_L3_LVL23  6'h0C
`define LEQ_IDX_STATUS    6'h0D

// Register select relative to the first gain register
`define LEQ_SEL_L2_LVL01  2'h0
`define LEQ_SEL_L2_LVL23  2'h1
`define LEQ_SEL_L3_LVL01  2'h2
`define LEQ_SEL_L3_LVL23  2'h3

// Gain storage entries, index is {lane3, level}
`define LEQ_ENT_L2_LVL0   3'h0
`define LEQ_ENT_L2_LVL1   3'h1
`define LEQ_ENT_L2_LVL2   3'h2
`define LEQ_ENT_L2_LVL3   3'h3
`define LEQ_ENT_L3_LVL0   3'h4
`define LEQ_ENT_L3_LVL1   3'h5
`define LEQ_ENT_L3_LVL2   3'h6
`define LEQ_ENT_L3_LVL3   3'h7
`define LEQ_LANE2_BIT     1'b0
`define LEQ_LANE3_BIT     1'b1
`define LEQ_LVL_FIXED     2'h1

// Gain field layout inside each register
`define LEQ_HI_MSB        6
`define LEQ_HI_LSB        4
`define LEQ_LO_MSB        2
`define LEQ_LO_LSB        0
`define LEQ_GAIN_RST      3'h0
`define LEQ_GAIN_ENTRIES  8

// Status register layout
`define LEQ_ST_L2_LSB     0
`define LEQ_ST_L3_LSB     4
`define LEQ_ST_ADAPT_BIT  8
`define LEQ_ST_FIXED_BIT  9
`define LEQ_ST_TMDS_BIT   10

// Gain steps in half-dB units, lower link rate
`define LEQ_LO_G1         6'h03
`define LEQ_LO_G2         6'h06
`define LEQ_LO_G3         6'h08
`define LEQ_LO_G4         6'h0A
`define LEQ_LO_G5         6'h0C
`define LEQ_LO_G6         6'h0E
`define LEQ_LO_G7         6'h12
// Gain steps in half-dB units, higher link rate
`define LEQ_HI_G1         6'h07
`define LEQ_HI_G2         6'h0C
`define LEQ_HI_G3         6'h10
`define LEQ_HI_G4         6'h14
`define LEQ_HI_G5         6'h1A
`define LEQ_HI_G6         6'h1E
`define LEQ_HI_G7         6'h24
`define LEQ_G0            6'h00

`endif

// [leq_lane_eq_select.v]
// What this block does
// - Lane 2 trained level 0 uses 0x09 bits 6:4
// - Lane 2 trained level 1 uses 0x09 bits 2:0
// - Lane 2 fixed gain: untrained or TMDS sink
// - Lane 2 trained level 2 uses 0x0A bits 6:4
// - Lane 2 trained level 3 uses 0x0A bits 2:0
// - Lane 3 trained level 0 uses 0x0B bits 6:4
// - Lane 3 level 1 and untrained fixed gain
// - Lane 3 levels 2,3 use 0x0C fields
// - Gain fields reset to zero, read/write
// - Codes map to rate-dependent increasing gain steps
//
// Implementation choice: register access over APB.
`timescale 1ns/1ns
`include "leq_regs.vh"

module leq_lane_eq_select (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        eq_override_en,
  input  wire        tmds_sink_sel,
  input  wire        train_en,
  input  wire [1:0]  train_level,
  input  wire        link_rate_high,
  output reg  [2:0]  lane2_gain_code,
  output reg  [2:0]  lane3_gain_code,
  output reg  [5:0]  lane2_gain_hdb,
  output reg  [5:0]  lane3_gain_hdb,
  output reg         adaptive_gain_mode
);

  // Gain selection modes, one-hot
  localparam [3:0] MODE_OFF   = 4'h1;
  localparam [3:0] MODE_ADAPT = 4'h2;
  localparam [3:0] MODE_FIXED = 4'h4;
  localparam [3:0] MODE_TMDS  = 4'h8;

  // Entry index is {lane3, level[1:0]}
  reg  [2:0]  gain_r [0:`LEQ_GAIN_ENTRIES-1];
  reg  [3:0]  mode_nxt;
  reg  [3:0]  mode_r;
  reg  [2:0]  l2_code_nxt;
  reg  [2:0]  l3_code_nxt;
  reg  [31:0] rdata_nxt;
  wire [5:0]  word_idx;
  wire [5:0]  rel_idx;
  wire [1:0]  reg_sel;
  wire        aligned;
  wire        gain_hit;
  wire        status_hit;
  wire        setup_ph;
  wire        wr_commit;
  integer     i;

  assign word_idx   = paddr[7:2];
  assign aligned    = (paddr[1:0] == `LEQ_BYTE_LSB_ZERO);
  assign rel_idx    = word_idx - `LEQ_IDX_L2_LVL01;
  assign reg_sel    = rel_idx[1:0];
  assign gain_hit   = aligned && (word_idx >= `LEQ_IDX_L2_LVL01) &&
                      (word_idx <= `LEQ_IDX_L3_LVL23);
  assign status_hit = aligned && (word_idx == `LEQ_IDX_STATUS);
  assign setup_ph   = psel && !penable;
  // pready is only high in the access cycle, so this fires once per transfer
  assign wr_commit  = psel && penable && pready && pwrite && gain_hit && pstrb[0];

  // Rate-dependent gain in half-dB steps
  function [5:0] gain_hdb;
    input [2:0] code;
    input       high;
    begin
      case (code)
        3'h1:    gain_hdb = high ? `LEQ_HI_G1 : `LEQ_LO_G1;
        3'h2:    gain_hdb = high ? `LEQ_HI_G2 : `LEQ_LO_G2;
        3'h3:    gain_hdb = high ? `LEQ_HI_G3 : `LEQ_LO_G3;
        3'h4:    gain_hdb = high ? `LEQ_HI_G4 : `LEQ_LO_G4;
        3'h5:    gain_hdb = high ? `LEQ_HI_G5 : `LEQ_LO_G5;
        3'h6:    gain_hdb = high ? `LEQ_HI_G6 : `LEQ_LO_G6;
        3'h7:    gain_hdb = high ? `LEQ_HI_G7 : `LEQ_LO_G7;
        default: gain_hdb = `LEQ_G0;
      endcase
    end
  endfunction

  always @* begin
    if (!eq_override_en) begin
      mode_nxt = MODE_OFF;
    end else if (tmds_sink_sel) begin
      mode_nxt = MODE_TMDS;
    end else if (train_en) begin
      mode_nxt = MODE_ADAPT;
    end else begin
      mode_nxt = MODE_FIXED;
    end
  end

  always @* begin
    case (mode_nxt)
      MODE_ADAPT: begin
        l2_code_nxt = gain_r[{`LEQ_LANE2_BIT, train_level}];
        l3_code_nxt = gain_r[{`LEQ_LANE3_BIT, train_level}];
      end
      MODE_FIXED: begin
        l2_code_nxt = gain_r[{`LEQ_LANE2_BIT, `LEQ_LVL_FIXED}];
        l3_code_nxt = gain_r[{`LEQ_LANE3_BIT, `LEQ_LVL_FIXED}];
      end
      MODE_TMDS: begin
        l2_code_nxt = gain_r[{`LEQ_LANE2_BIT, `LEQ_LVL_FIXED}];
        // Lane 3 has no fixed gain with the TMDS sink
        l3_code_nxt = `LEQ_GAIN_RST;
      end
      default: begin
        // Without override another source owns the equalizer
        l2_code_nxt = `LEQ_GAIN_RST;
        l3_code_nxt = `LEQ_GAIN_RST;
      end
    endcase
  end

  always @* begin
    rdata_nxt = {`LEQ_DATA_W{1'b0}};
    if (gain_hit) begin
      // Bits 7 and 3 stay zero
      case (reg_sel)
        `LEQ_SEL_L2_LVL01: begin
          rdata_nxt[`LEQ_HI_MSB:`LEQ_HI_LSB] = gain_r[`LEQ_ENT_L2_LVL0];
          rdata_nxt[`LEQ_LO_MSB:`LEQ_LO_LSB] = gain_r[`LEQ_ENT_L2_LVL1];
        end
        `LEQ_SEL_L2_LVL23: begin
          rdata_nxt[`LEQ_HI_MSB:`LEQ_HI_LSB] = gain_r[`LEQ_ENT_L2_LVL2];
          rdata_nxt[`LEQ_LO_MSB:`LEQ_LO_LSB] = gain_r[`LEQ_ENT_L2_LVL3];
        end
        `LEQ_SEL_L3_LVL01: begin
          rdata_nxt[`LEQ_HI_MSB:`LEQ_HI_LSB] = gain_r[`LEQ_ENT_L3_LVL0];
          rdata_nxt[`LEQ_LO_MSB:`LEQ_LO_LSB] = gain_r[`LEQ_ENT_L3_LVL1];
        end
        `LEQ_SEL_L3_LVL23: begin
          rdata_nxt[`LEQ_HI_MSB:`LEQ_HI_LSB] = gain_r[`LEQ_ENT_L3_LVL2];
          rdata_nxt[`LEQ_LO_MSB:`LEQ_LO_LSB] = gain_r[`LEQ_ENT_L3_LVL3];
        end
        default: begin
          rdata_nxt = {`LEQ_DATA_W{1'b0}};
        end
      endcase
    end else if (status_hit) begin
      rdata_nxt[`LEQ_ST_L2_LSB+2:`LEQ_ST_L2_LSB] = lane2_gain_code;
      rdata_nxt[`LEQ_ST_L3_LSB+2:`LEQ_ST_L3_LSB] = lane3_gain_code;
      rdata_nxt[`LEQ_ST_ADAPT_BIT]               = (mode_r == MODE_ADAPT);
      rdata_nxt[`LEQ_ST_FIXED_BIT]               = (mode_r == MODE_FIXED);
      rdata_nxt[`LEQ_ST_TMDS_BIT]                = (mode_r == MODE_TMDS);
    end
  end

  // Gain storage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < `LEQ_GAIN_ENTRIES; i = i + 1) begin
        gain_r[i] <= `LEQ_GAIN_RST;
      end
    end else if (wr_commit) begin
      // Bits 7 and 3 have no storage, so writes to them vanish
      case (reg_sel)
        `LEQ_SEL_L2_LVL01: begin
          gain_r[`LEQ_ENT_L2_LVL0] <= pwdata[`LEQ_HI_MSB:`LEQ_HI_LSB];
          gain_r[`LEQ_ENT_L2_LVL1] <= pwdata[`LEQ_LO_MSB:`LEQ_LO_LSB];
        end
        `LEQ_SEL_L2_LVL23: begin
          gain_r[`LEQ_ENT_L2_LVL2] <= pwdata[`LEQ_HI_MSB:`LEQ_HI_LSB];
          gain_r[`LEQ_ENT_L2_LVL3] <= pwdata[`LEQ_LO_MSB:`LEQ_LO_LSB];
        end
        `LEQ_SEL_L3_LVL01: begin
          gain_r[`LEQ_ENT_L3_LVL0] <= pwdata[`LEQ_HI_MSB:`LEQ_HI_LSB];
          gain_r[`LEQ_ENT_L3_LVL1] <= pwdata[`LEQ_LO_MSB:`LEQ_LO_LSB];
        end
        `LEQ_SEL_L3_LVL23: begin
          gain_r[`LEQ_ENT_L3_LVL2] <= pwdata[`LEQ_HI_MSB:`LEQ_HI_LSB];
          gain_r[`LEQ_ENT_L3_LVL3] <= pwdata[`LEQ_LO_MSB:`LEQ_LO_LSB];
        end
        default: begin
          gain_r[`LEQ_ENT_L2_LVL0] <= gain_r[`LEQ_ENT_L2_LVL0];
        end
      endcase
    end
  end

  // APB slave: fixed single access cycle, data captured in setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= {`LEQ_DATA_W{1'b0}};
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph && !gain_hit && !(status_hit && !pwrite);
      if (setup_ph) begin
        prdata <= pwrite ? {`LEQ_DATA_W{1'b0}} : rdata_nxt;
      end
    end
  end

  // Applied gain, registered so every output comes from a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r             <= MODE_OFF;
      lane2_gain_code    <= `LEQ_GAIN_RST;
      lane3_gain_code    <= `LEQ_GAIN_RST;
      lane2_gain_hdb     <= `LEQ_G0;
      lane3_gain_hdb     <= `LEQ_G0;
      adaptive_gain_mode <= 1'b0;
    end else begin
      mode_r             <= mode_nxt;
      lane2_gain_code    <= l2_code_nxt;
      lane3_gain_code    <= l3_code_nxt;
      lane2_gain_hdb     <= gain_hdb(l2_code_nxt, link_rate_high);
      lane3_gain_hdb     <= gain_hdb(l3_code_nxt, link_rate_high);
      adaptive_gain_mode <= (mode_nxt == MODE_ADAPT);
    end
  end

endmodule // leq_lane_eq_select

// [leq_sva.sv]
`timescale 1ns/1ns
module leq_sva (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        eq_override_en,
  input logic        tmds_sink_sel,
  input logic        train_en,
  input logic        link_rate_high,
  input logic [2:0]  lane2_gain_code,
  input logic [2:0]  lane3_gain_code,
  input logic [5:0]  lane2_gain_hdb,
  input logic        adaptive_gain_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; psel && !penable; endsequence
  sequence access_s; psel && penable && pready; endsequence
  AST_RDY: assert property (setup_s |=> access_s) else $error("no ready");
  AST_ONE: assert property (pready |=> !pready) else $error("ready held");
  AST_ERR: assert property (pslverr |-> pready) else $error("lone error");
  AST_RSV: assert property (psel && penable && pready && !pwrite && paddr != 8'h34
    |-> prdata[31:7] == 0 && !prdata[3]) else $error("reserved bits set");
  AST_OFF: assert property (!eq_override_en |=> lane2_gain_code == 0
    && lane3_gain_code == 0) else $error("gain without override");
  AST_ADM: assert property (adaptive_gain_mode ==
    $past(eq_override_en && !tmds_sink_sel && train_en)) else $error("mode wrong");
  AST_TL3: assert property (eq_override_en && tmds_sink_sel |=>
    lane3_gain_code == 0) else $error("lane 3 gain in tmds");
  AST_LO: assert property (lane2_gain_code == 3'h3 && !$past(link_rate_high)
    |-> lane2_gain_hdb == 6'h08) else $error("low rate step");
  AST_HI: assert property (lane2_gain_code == 3'h1 && $past(link_rate_high)
    |-> lane2_gain_hdb == 6'h07) else $error("high rate step");
endmodule // leq_sva
bind leq_lane_eq_select leq_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .eq_override_en(eq_override_en), .tmds_sink_sel(tmds_sink_sel),
  .train_en(train_en), .link_rate_high(link_rate_high), .lane2_gain_code(lane2_gain_code),
  .lane3_gain_code(lane3_gain_code), .lane2_gain_hdb(lane2_gain_hdb),
  .adaptive_gain_mode(adaptive_gain_mode));

// [leq_host.sv]
`timescale 1ns/1ns
module leq_host (
  input  logic        pclk,
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [7:0]  paddr,
  output logic [31:0] pwdata,
  input  logic [31:0] prdata,
  input  logic        pready,
  input  logic        pslverr
);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
endmodule // leq_host

// [lane_eq_select_regs_test.sv]
`timescale 1ns/1ns
module lane_eq_select_regs_test;
  logic        pclk = 0, presetn = 0, ovr = 0, tmds = 0, trn = 0, rate = 0, er;
  logic [1:0]  lvl = 0;
  logic [31:0] rd;
  int          error_cnt = 0, checked = 0, cyc = 0;
  wire         psel, penable, pwrite, pready, pslverr, adm;
  wire [7:0]   paddr;
  wire [31:0]  pwdata, prdata;
  wire [2:0]   c2, c3;
  wire [5:0]   h2, h3;
  always #20 pclk = ~pclk;
  leq_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  leq_lane_eq_select u_leq_lane_eq_select (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .eq_override_en(ovr),
    .tmds_sink_sel(tmds), .train_en(trn), .train_level(lvl), .link_rate_high(rate),
    .lane2_gain_code(c2), .lane3_gain_code(c3), .lane2_gain_hdb(h2), .lane3_gain_hdb(h3),
    .adaptive_gain_mode(adm));
  task automatic chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d, x, input e);
    host.xfer(w, a, d, rd, er);
    if (!w) chk(rd, x);
    chk({31'h0, er}, {31'h0, e});
  endtask
  task automatic sett(input logic o, t, r, input logic [1:0] l, input logic hr);
    @(posedge pclk);
    {ovr, tmds, trn, lvl, rate} <= {o, t, r, l, hr};
    repeat (2) @(posedge pclk);
    #1;
  endtask
  task automatic t_regs;
    for (int i = 0; i < 4; i++) rw(0, 8'(8'h24 + 4 * i), 0, 0, 0);
    for (int i = 0; i < 4; i++) begin
      rw(1, 8'(8'h24 + 4 * i), 32'hFFFFFFFF, 0, 0);
      rw(0, 8'(8'h24 + 4 * i), 0, 32'h77, 0);
    end
    rw(1, 8'h40, 32'h11, 0, 1);
    rw(0, 8'h40, 0, 0, 1);
    $display("test regs done");
  endtask
  task automatic t_train;
    logic [11:0] e2 = {3'h3, 3'h4, 3'h1, 3'h2};
    logic [11:0] e3 = {3'h7, 3'h0, 3'h5, 3'h6};
    rw(1, 8'h24, 32'h21, 0, 0);
    rw(1, 8'h28, 32'h43, 0, 0);
    rw(1, 8'h2C, 32'h65, 0, 0);
    rw(1, 8'h30, 32'h07, 0, 0);
    for (int l = 0; l < 4; l++) begin
      sett(1, 0, 1, 2'(l), 0);
      chk({29'h0, c2}, {29'h0, e2[3*l +: 3]});
      chk({29'h0, c3}, {29'h0, e3[3*l +: 3]});
      chk({31'h0, adm}, 32'h1);
    end
    $display("test train done");
  endtask
  task automatic t_fixed;
    sett(1, 0, 0, 2'h3, 0);
    chk({14'h0, c2, c3, h2, h3}, {14'h0, 3'h1, 3'h5, 6'h03, 6'h0C});
    rw(0, 8'h34, 0, 32'h251, 0);
    sett(1, 1, 1, 2'h0, 1);
    chk({14'h0, c2, c3, h2, h3}, {14'h0, 3'h1, 3'h0, 6'h07, 6'h00});
    rw(0, 8'h34, 0, 32'h401, 0);
    rw(1, 8'h34, 0, 0, 1);
    sett(0, 0, 1, 2'h0, 1);
    chk({25'h0, c2, c3, adm}, 0);
    $display("test fixed done");
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      report_and_stop;
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    t_regs;
    t_train;
    t_fixed;
    report_and_stop;
  end
endmodule // lane_eq_select_regs_test
